/* File: hw/cpcmd_defs.svh */
// constants of the command port: register layout, codes and timing
//
// Contract
// - host sets pending flag with each command
// - device clears pending flag when command done
// - host waits for clear flag, except reset
// - soft reset allowed anytime, flag still set
// - 8-bit read-write register, zero after reset
// - field layout fixed; bit 3 written zero
// - soft reset: flag clear in two, ~60 clocks
// - host reinitialises once flag clears after reset
// - soft reset restores controllers, keeps configuration
// - soft reset keeps interrupt pending bits
// - opcodes: halt, resume, resync, clear block check
// - bus commands: abort request, timeout, two reserved
// - bus commands use channel 10 with flag
// - channel select picks controller; 11 reserved
// - transmit effect may lag the flag clear
// - commands rank below refresh, above channels
// - resync within 41 clocks, others under 20
// - worst latency adds refresh and protocol terms
`ifndef CPCMD_DEFS_SVH
`define CPCMD_DEFS_SVH

// ==========================================
// command register fields
`define CPCMD_RST_BIT     7
`define CPCMD_BUS_BIT     6
`define CPCMD_OP_HI       5
`define CPCMD_OP_LO       4
`define CPCMD_RSVD_BIT    3
`define CPCMD_CH_HI       2
`define CPCMD_CH_LO       1
`define CPCMD_FLAG_BIT    0
`define CPCMD_RESET_VAL   8'h00
`define CPCMD_BUS_CHAN    2'h2
`define CPCMD_OP_HALT     2'h0
`define CPCMD_OP_RESUME   2'h1
`define CPCMD_OP_RESYNC   2'h2
`define CPCMD_OP_CLRBC    2'h3
`define CPCMD_OP_ABORT    2'h0
`define CPCMD_OP_TIMEOUT  2'h1

// ==========================================
// execution timing in clocks
`define CPCMD_RESYNC_CLKS 6'h29
`define CPCMD_OTHER_CLKS  6'h13
`define CPCMD_SRST_CLKS   6'h3c
`define CPCMD_LAT_REFRESH 25
`define CPCMD_LAT_BISYNC  205
`define CPCMD_LAT_HDLC    165
`define CPCMD_LAT_UART    150
`define CPCMD_LAT_DDCMP   140

// ==========================================
// host register map (axi4-lite, byte addresses)
`define CPCMD_ADDR_CMD    4'h0
`define CPCMD_ADDR_STAT   4'h4
`define CPCMD_STAT_BUSY   0
`define CPCMD_STAT_REFUSE 1
`define CPCMD_RESP_OKAY   2'h0
`define CPCMD_RESP_SLVERR 2'h2

`endif

/* File: hw/cpcmd_dev.sv */
// communications processor end: command register, scheduler and executor
`timescale 1ns/100ps
`default_nettype none
`include "cpcmd_defs.svh"
module cpcmd_dev (
	input  wire logic       aclk,
	input  wire logic       aresetn,
	cpcmd_if.dev            link,
	input  wire logic       refresh_req,
	input  wire logic [5:0] chan_req,
	output logic            refresh_gnt,
	output logic            cmd_gnt,
	output logic      [5:0] chan_gnt,
	output logic            halt_tx,
	output logic            resume_tx,
	output logic            resync_rx,
	output logic            clear_bc,
	output logic            abort_req,
	output logic            timeout_cmd,
	output logic      [2:0] chan_onehot,
	output logic            ctrl_reset
);

	// ==========================================
	// helpers

	// lowest index wins among the serial channel requests
	function automatic logic [5:0] pick_first(input logic [5:0] req);
		logic [5:0] g;
		g = 6'h00;
		for (int i = 5; i >= 0; i--) begin
			if (req[i]) begin
				g = 6'h00;
				g[i] = 1'b1;
			end
		end
		return g;
	endfunction

	function automatic logic [2:0] chan_decode(input logic [1:0] ch);
		logic [2:0] d;
		d = 3'h0;
		if (ch != 2'h3) begin
			d[ch] = 1'b1;
		end
		return d;
	endfunction

	// ==========================================
	// state

	cpcmd_pkg::cpcmd_byte_t     cmd_reg;
	cpcmd_pkg::cpcmd_state_e    state_reg;
	cpcmd_pkg::cpcmd_state_e    state_next;
	logic                 [5:0] count_reg;
	logic                       pending;
	logic                       soft_rst;
	logic                       bus_sel;
	logic                 [1:0] opcode;
	logic                 [1:0] chan;
	logic                       start;
	logic                       done;
	logic                       srst_start;
	logic                       srst_done;

	assign pending    = cmd_reg[`CPCMD_FLAG_BIT];
	assign soft_rst   = cmd_reg[`CPCMD_RST_BIT];
	assign bus_sel    = cmd_reg[`CPCMD_BUS_BIT];
	assign opcode     = cmd_reg[`CPCMD_OP_HI:`CPCMD_OP_LO];
	assign chan       = cmd_reg[`CPCMD_CH_HI:`CPCMD_CH_LO];
	assign link.cmd_rdata = cmd_reg;

	// soft reset is detected in hardware whatever the executor is doing
	assign srst_start = soft_rst && (state_reg != cpcmd_pkg::CPCMD_SRST);
	// refresh outranks a waiting command
	assign start      = (state_reg == cpcmd_pkg::CPCMD_IDLE) && pending && !soft_rst
		&& !refresh_req;
	// execution pauses while refresh holds the scheduler; each refresh stall adds to the worst-case latency
	assign done       = (state_reg == cpcmd_pkg::CPCMD_EXEC) && !refresh_req
		&& (count_reg == 6'h01);
	assign srst_done  = (state_reg == cpcmd_pkg::CPCMD_SRST) && (count_reg == 6'h01);

	// ==========================================
	// scheduler state machine

	always_comb begin
		state_next = state_reg;
		case (state_reg)
			cpcmd_pkg::CPCMD_IDLE: begin
				if (srst_start) begin
					state_next = cpcmd_pkg::CPCMD_SRST;
				end else if (start) begin
					state_next = cpcmd_pkg::CPCMD_EXEC;
				end
			end
			cpcmd_pkg::CPCMD_EXEC: begin
				if (srst_start) begin
					state_next = cpcmd_pkg::CPCMD_SRST;
				end else if (done) begin
					state_next = cpcmd_pkg::CPCMD_IDLE;
				end
			end
			cpcmd_pkg::CPCMD_SRST: begin
				if (srst_done) begin
					state_next = cpcmd_pkg::CPCMD_IDLE;
				end
			end
			default: begin
				state_next = cpcmd_pkg::CPCMD_IDLE;
			end
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_reg <= cpcmd_pkg::CPCMD_IDLE;
		end else begin
			state_reg <= state_next;
		end
	end

	// ==========================================
	// execution counter

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			count_reg <= 6'h00;
		end else if (srst_start) begin
			count_reg <= `CPCMD_SRST_CLKS;
		end else if (start) begin
			// resync is the long one; every other command stays under 20
			if (!bus_sel && opcode == `CPCMD_OP_RESYNC) begin
				count_reg <= `CPCMD_RESYNC_CLKS;
			end else begin
				count_reg <= `CPCMD_OTHER_CLKS;
			end
		end else if (srst_done || done) begin
			count_reg <= 6'h00;
		end else if (state_reg == cpcmd_pkg::CPCMD_SRST) begin
			count_reg <= count_reg - 6'h01;
		end else if (state_reg == cpcmd_pkg::CPCMD_EXEC && !refresh_req) begin
			count_reg <= count_reg - 6'h01;
		end
	end

	// ==========================================
	// command register

	// a write while busy is dropped unless it requests soft reset;
	// the flag clears the edge after soft reset is seen, within two clocks
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cmd_reg <= `CPCMD_RESET_VAL;
		end else if (link.cmd_wr && (!pending || link.cmd_wdata[`CPCMD_RST_BIT])) begin
			cmd_reg <= link.cmd_wdata;
			cmd_reg[`CPCMD_RSVD_BIT] <= 1'b0;
		end else if (srst_start) begin
			cmd_reg[`CPCMD_FLAG_BIT] <= 1'b0;
		end else if (srst_done) begin
			cmd_reg[`CPCMD_RST_BIT] <= 1'b0;
		end else if (done) begin
			cmd_reg[`CPCMD_FLAG_BIT] <= 1'b0;
		end
	end

	// ==========================================
	// controller reset

	// only the serial, port and management controllers are reset; the
	// mode, mask, configuration and interrupt pending state lie outside
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl_reset <= 1'b0;
		end else begin
			ctrl_reset <= (state_next == cpcmd_pkg::CPCMD_SRST);
		end
	end

	// ==========================================
	// command decode, one pulse at the start of execution

	// transmit halt and resume only reach the controller here; the line
	// itself may change much later because of its transmit fifo
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			halt_tx     <= 1'b0;
			resume_tx   <= 1'b0;
			resync_rx   <= 1'b0;
			clear_bc    <= 1'b0;
			abort_req   <= 1'b0;
			timeout_cmd <= 1'b0;
			chan_onehot <= 3'h0;
		end else begin
			halt_tx     <= start && !bus_sel && opcode == `CPCMD_OP_HALT;
			resume_tx   <= start && !bus_sel && opcode == `CPCMD_OP_RESUME;
			resync_rx   <= start && !bus_sel && opcode == `CPCMD_OP_RESYNC;
			clear_bc    <= start && !bus_sel && opcode == `CPCMD_OP_CLRBC;
			abort_req   <= start && bus_sel && opcode == `CPCMD_OP_ABORT;
			timeout_cmd <= start && bus_sel && opcode == `CPCMD_OP_TIMEOUT;
			chan_onehot <= start ? chan_decode(chan) : 3'h0;
		end
	end

	// ==========================================
	// service grants

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			refresh_gnt <= 1'b0;
			cmd_gnt     <= 1'b0;
			chan_gnt    <= 6'h00;
		end else begin
			refresh_gnt <= refresh_req;
			cmd_gnt     <= start;
			// channels wait while a command is pending or running
			if (!refresh_req && !pending && state_reg == cpcmd_pkg::CPCMD_IDLE) begin
				chan_gnt <= pick_first(chan_req);
			end else begin
				chan_gnt <= 6'h00;
			end
		end
	end

endmodule
`default_nettype wire

/* File: hw/cpcmd_host.sv */
// host end: axi4-lite registers that issue commands over the link
`timescale 1ns/100ps
`default_nettype none
`include "cpcmd_defs.svh"
module cpcmd_host (
	input  wire logic        aclk,
	input  wire logic        aresetn,
	cpcmd_if.host            link,
	input  wire logic  [3:0] s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic  [3:0] s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic       [1:0] s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic  [3:0] s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic      [31:0] s_axi_rdata,
	output logic       [1:0] s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready
);

	// ==========================================
	// write channel capture

	logic                   aw_held;
	logic                   w_held;
	logic             [3:0] waddr_reg;
	logic            [31:0] wdata_reg;
	logic             [3:0] wstrb_reg;
	logic                   do_write;
	logic                   busy;
	logic                   refused_reg;
	logic                   issue;
	logic                   refuse;
	cpcmd_pkg::cpcmd_byte_t cmd_next;

	assign busy     = link.cmd_rdata[`CPCMD_FLAG_BIT];
	assign do_write = aw_held && w_held && !s_axi_bvalid;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held       <= 1'b0;
			s_axi_awready <= 1'b0;
			waddr_reg     <= 4'h0;
		end else if (s_axi_awvalid && s_axi_awready) begin
			aw_held       <= 1'b1;
			s_axi_awready <= 1'b0;
			waddr_reg     <= s_axi_awaddr;
		end else begin
			if (do_write) begin
				aw_held <= 1'b0;
			end
			s_axi_awready <= s_axi_awvalid && !aw_held && !s_axi_bvalid;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			w_held       <= 1'b0;
			s_axi_wready <= 1'b0;
			wdata_reg    <= 32'h0000_0000;
			wstrb_reg    <= 4'h0;
		end else if (s_axi_wvalid && s_axi_wready) begin
			w_held       <= 1'b1;
			s_axi_wready <= 1'b0;
			wdata_reg    <= s_axi_wdata;
			wstrb_reg    <= s_axi_wstrb;
		end else begin
			if (do_write) begin
				w_held <= 1'b0;
			end
			s_axi_wready <= s_axi_wvalid && !w_held && !s_axi_bvalid;
		end
	end

	// ==========================================
	// command issue

	// the bus answer spaces writes far enough that the flag set by the
	// previous command is already visible when the next one arrives
	always_comb begin
		cmd_next = wdata_reg[7:0];
		cmd_next[`CPCMD_FLAG_BIT] = 1'b1;
		cmd_next[`CPCMD_RSVD_BIT] = 1'b0;
		if (cmd_next[`CPCMD_BUS_BIT]) begin
			cmd_next[`CPCMD_CH_HI:`CPCMD_CH_LO] = `CPCMD_BUS_CHAN;
		end
	end

	assign refuse = do_write && waddr_reg == `CPCMD_ADDR_CMD && wstrb_reg[0]
		&& busy && !cmd_next[`CPCMD_RST_BIT];
	assign issue  = do_write && waddr_reg == `CPCMD_ADDR_CMD && wstrb_reg[0] && !refuse;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			link.cmd_wr    <= 1'b0;
			link.cmd_wdata <= `CPCMD_RESET_VAL;
		end else begin
			link.cmd_wr <= issue;
			if (issue) begin
				link.cmd_wdata <= cmd_next;
			end
		end
	end

	// a new refusal wins over a clear in the same cycle
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			refused_reg <= 1'b0;
		end else if (refuse) begin
			refused_reg <= 1'b1;
		end else if (do_write && waddr_reg == `CPCMD_ADDR_STAT && wstrb_reg[0]
			&& wdata_reg[`CPCMD_STAT_REFUSE]) begin
			refused_reg <= 1'b0;
		end
	end

	// ==========================================
	// write response

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= `CPCMD_RESP_OKAY;
		end else if (do_write) begin
			s_axi_bvalid <= 1'b1;
			if (waddr_reg == `CPCMD_ADDR_CMD || waddr_reg == `CPCMD_ADDR_STAT) begin
				s_axi_bresp <= `CPCMD_RESP_OKAY;
			end else begin
				s_axi_bresp <= `CPCMD_RESP_SLVERR;
			end
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// ==========================================
	// read channel

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0000_0000;
			s_axi_rresp   <= `CPCMD_RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b1;
			s_axi_rdata   <= 32'h0000_0000;
			s_axi_rresp   <= `CPCMD_RESP_OKAY;
			case (s_axi_araddr)
				`CPCMD_ADDR_CMD: begin
					s_axi_rdata[7:0] <= link.cmd_rdata;
				end
				`CPCMD_ADDR_STAT: begin
					s_axi_rdata[`CPCMD_STAT_BUSY]   <= busy;
					s_axi_rdata[`CPCMD_STAT_REFUSE] <= refused_reg;
				end
				default: begin
					s_axi_rresp <= `CPCMD_RESP_SLVERR;
				end
			endcase
		end else begin
			if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
			s_axi_arready <= s_axi_arvalid && !s_axi_rvalid && !s_axi_arready;
		end
	end

endmodule
`default_nettype wire

/* File: hw/cpcmd_if.sv */
// link between host and communications processor command register
`timescale 1ns/100ps
`default_nettype none
interface cpcmd_if;
	logic                  cmd_wr;
	cpcmd_pkg::cpcmd_byte_t cmd_wdata;
	cpcmd_pkg::cpcmd_byte_t cmd_rdata;

	modport dev (
		input  cmd_wr,
		input  cmd_wdata,
		output cmd_rdata
	);
	modport host (
		output cmd_wr,
		output cmd_wdata,
		input  cmd_rdata
	);
endinterface
`default_nettype wire

/* File: hw/cpcmd_pkg.sv */
// types shared by both ends of the command port
`default_nettype none
package cpcmd_pkg;
	typedef logic [7:0] cpcmd_byte_t;
	typedef enum logic [1:0] {
		CPCMD_IDLE = 2'b00,
		CPCMD_EXEC = 2'b01,
		CPCMD_SRST = 2'b10
	} cpcmd_state_e;
endpackage
`default_nettype wire

/* File: tb/cpcmd_monitor.sv */
// checker on the command link between the host and device ends
`timescale 1ns/100ps
`default_nettype none
module cpcmd_monitor (
	input wire logic                   aclk,
	input wire logic                   aresetn,
	input wire logic                   cmd_wr,
	input wire cpcmd_pkg::cpcmd_byte_t cmd_wdata,
	input wire cpcmd_pkg::cpcmd_byte_t cmd_rdata
);
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	// =========================================
	// accepted link writes by kind
	logic take;
	logic srst;
	logic norm;
	logic rsy;
	assign take = cmd_wr && (!cmd_rdata[0] || cmd_wdata[7]);
	assign srst = take && cmd_wdata[7];
	assign rsy  = take && !cmd_wdata[7] && (cmd_wdata[6:4] == 3'h2);
	assign norm = take && !cmd_wdata[7] && (cmd_wdata[6:4] != 3'h2);

	// =========================================
	// assertions
	// bounds allow 28 clocks of refresh stall on top of execution
	a_reset_zero: assert property ($rose(aresetn) |-> cmd_rdata == 8'h00)
		else $error("command register not zero after reset");
	a_write_shown: assert property (take |=> cmd_rdata == ($past(cmd_wdata) & 8'hf7))
		else $error("command register does not show accepted byte");
	a_rsvd_zero: assert property (cmd_rdata[3] == 1'b0)
		else $error("reserved bit reads one");
	a_flag_cause: assert property ($rose(cmd_rdata[0]) |-> $past(cmd_wr))
		else $error("pending flag rose without a write");
	a_flag_holds: assert property (norm |=> cmd_rdata[0] [*8])
		else $error("pending flag dropped too early");
	a_normal_done: assert property (norm |-> ##[2:49] !cmd_rdata[0])
		else $error("normal command did not complete in time");
	a_resync_done: assert property (rsy |-> ##[2:71] !cmd_rdata[0])
		else $error("resync command did not complete in time");
	a_srst_flag: assert property (srst |-> ##2 (!cmd_rdata[0] && cmd_rdata[7]))
		else $error("soft reset flag not cleared in two clocks");
	a_srst_selfclr: assert property (srst |-> ##[58:66] cmd_rdata == 8'h00)
		else $error("soft reset bit not cleared by device");
	a_idle_stable: assert property (!cmd_wr && !cmd_rdata[0] && !cmd_rdata[7] |=> $stable(cmd_rdata))
		else $error("idle command register changed");

	c_srst: cover property (srst);
	c_resync: cover property (rsy);
	c_normal: cover property (norm ##[2:49] !cmd_rdata[0]);
endmodule
`default_nettype wire

/* File: tb/tb_top.sv */
// self-checking bench: host and device ends joined over the command link
`timescale 1ns/100ps
`default_nettype none
module tb_top;
	logic        aclk = 1'b0;
	logic        aresetn = 1'b0;
	logic        refresh_req = 1'b0;
	logic [5:0]  chan_req = 6'h00;
	logic        refresh_gnt, cmd_gnt, halt_tx, resume_tx, resync_rx;
	logic        clear_bc, abort_req, timeout_cmd, ctrl_reset;
	logic [5:0]  chan_gnt;
	logic [2:0]  chan_onehot;
	logic [3:0]  s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hf;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
	logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	int          mismatches = 0, comparisons = 0, cyc = 0;

	always #12.5 aclk = ~aclk;
	always @(posedge aclk) cyc <= cyc + 1;

	cpcmd_if cpcmd_if_i ();
	cpcmd_dev cpcmd_dev_i (.aclk, .aresetn, .link(cpcmd_if_i), .refresh_req, .chan_req, .refresh_gnt,
		.cmd_gnt, .chan_gnt, .halt_tx, .resume_tx, .resync_rx, .clear_bc, .abort_req, .timeout_cmd,
		.chan_onehot, .ctrl_reset);
	cpcmd_host cpcmd_host_i (.aclk, .aresetn, .link(cpcmd_if_i), .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
		.s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
	cpcmd_monitor cpcmd_monitor_i (.aclk, .aresetn, .cmd_wr(cpcmd_if_i.cmd_wr),
		.cmd_wdata(cpcmd_if_i.cmd_wdata), .cmd_rdata(cpcmd_if_i.cmd_rdata));

	// =========================================
	// tasks
	task automatic stop_test;
		$display("comparisons %0d mismatches %0d", comparisons, mismatches);
		if (mismatches == 0 && comparisons > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			mismatches++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic axw(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_awready)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wready)
				s_axi_wvalid <= 1'b0;
		end while (!s_axi_bvalid);
		r = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask

	task automatic axr(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_arready)
				s_axi_arvalid <= 1'b0;
		end while (!s_axi_rvalid);
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask

	// issue one command, check its pulses, readback while pending and execution time
	task automatic docmd(input logic [7:0] c, input logic [8:0] e, input int lim);
		logic [1:0]  r;
		logic [31:0] d;
		logic [8:0]  v;
		int          t0;
		axw(4'h0, {24'h0, c}, r);
		chk(r, 0);
		while (!cmd_gnt)
			@(posedge aclk);
		t0 = cyc;
		v = {chan_onehot, timeout_cmd, abort_req, clear_bc, resync_rx, resume_tx, halt_tx};
		// reserved bus opcodes fire no command pulse, yet the channel pulse still marks the start
		chk(v, e);
		axr(4'h0, d, r);
		chk(d, {24'h0, c[7:4], 1'b0, c[6] ? 2'b10 : c[2:1], 1'b1});
		while (cpcmd_if_i.cmd_rdata[0])
			@(posedge aclk);
		chk(cyc - t0 <= lim, 1);
	endtask

	// =========================================
	// test sequence
	initial begin
		logic [1:0]  r;
		logic [31:0] d;
		logic [7:0]  c;
		logic [8:0]  e;
		int          t0;
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		axr(4'h0, d, r);
		chk(d, 32'h0);
		axr(4'h8, d, r);
		chk({d[29:0], r}, 32'h2);
		axw(4'h8, 32'h81, r);
		chk(r, 32'h2);
		// a command write without its low byte lane must not reach the link
		s_axi_wstrb <= 4'he;
		axw(4'h0, 32'h01, r);
		s_axi_wstrb <= 4'hf;
		chk(r, 32'h0);
		axr(4'h0, d, r);
		chk(d, 32'h0);
		$display("test reset values done");

		axw(4'h0, 32'h21, r);
		axw(4'h0, 32'h01, r);
		chk(r, 32'h0);
		axr(4'h4, d, r);
		chk(d, 32'h3);
		axw(4'h4, 32'h2, r);
		axr(4'h4, d, r);
		chk(d, 32'h1);
		// flag left out on purpose: the host adds it
		axw(4'h0, 32'h80, r);
		while (!ctrl_reset)
			@(posedge aclk);
		t0 = cyc;
		chk(cpcmd_if_i.cmd_rdata, 8'h80);
		while (ctrl_reset)
			@(posedge aclk);
		chk(cyc - t0 >= 58 && cyc - t0 <= 62, 1);
		axr(4'h0, d, r);
		chk(d, 32'h0);
		$display("test soft reset done");

		for (int k = 0; k < 8; k++) begin
			c = {1'b0, k[2:0], 1'b1, k[1:0], 1'b1};
			e[5:0] = k < 6 ? 6'h01 << k : 6'h00;
			e[8:6] = k >= 4 ? 3'h4 : (k == 3 ? 3'h0 : 3'h1 << k);
			docmd(c, e, k == 2 ? 41 : 19);
		end
		$display("test command codes done");

		chan_req <= 6'h0c;
		repeat (3) @(posedge aclk);
		chk(chan_gnt, 6'h04);
		refresh_req <= 1'b1;
		repeat (3) @(posedge aclk);
		chk({refresh_gnt, chan_gnt}, 7'h40);
		axw(4'h0, 32'h01, r);
		// refresh outranks the command: no execution may start while it is held
		repeat (4) begin
			@(posedge aclk);
			chk(cmd_gnt, 1'b0);
		end
		chk({chan_gnt, cpcmd_if_i.cmd_rdata[0]}, 7'h01);
		refresh_req <= 1'b0;
		while (cpcmd_if_i.cmd_rdata[0]) begin
			@(posedge aclk);
			chk(chan_gnt, 6'h00);
		end
		repeat (3) @(posedge aclk);
		chk(chan_gnt, 6'h04);
		$display("test priority done");
		stop_test();
	end

	initial begin
		repeat (4000) @(posedge aclk);
		mismatches++;
		stop_test();
	end
endmodule
`default_nettype wire
